//--- pkg/pfm_pkg.sv
// Constants of the port pin function multiplexer: register map, widths and reset values.
package pfm_pkg;

    localparam int P0_W  = 8;
    localparam int P1_W  = 2;
    localparam int P2_W  = 6;
    localparam int P3_W  = 5;
    localparam int P5_W  = 4;
    localparam int P6_W  = 8;
    localparam int P7_W  = 4;
    localparam int P8_W  = 8;
    localparam int INT_W = 4;
    localparam int SEG_W = 12;
    localparam int PIN_W = P0_W + P1_W + P2_W + P3_W + P5_W + P6_W + P7_W + P8_W;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Data registers.
    localparam logic [7:0] ADDR_P0_DATA   = 8'h00;
    localparam logic [7:0] ADDR_P1_DATA   = 8'h01;
    localparam logic [7:0] ADDR_P2_DATA   = 8'h02;
    localparam logic [7:0] ADDR_P3_DATA   = 8'h03;
    localparam logic [7:0] ADDR_P5_DATA   = 8'h04;
    localparam logic [7:0] ADDR_P6_DATA   = 8'h05;
    localparam logic [7:0] ADDR_P7_DATA   = 8'h06;
    localparam logic [7:0] ADDR_P8_DATA   = 8'h07;
    // Direction registers, a one makes the bit an input.
    localparam logic [7:0] ADDR_P0_DIR    = 8'h10;
    localparam logic [7:0] ADDR_P1_DIR    = 8'h11;
    localparam logic [7:0] ADDR_P2_DIR    = 8'h12;
    localparam logic [7:0] ADDR_P3_DIR    = 8'h13;
    localparam logic [7:0] ADDR_P5_DIR    = 8'h14;
    localparam logic [7:0] ADDR_P8_DIR    = 8'h15;
    // Pull-up option registers.
    localparam logic [7:0] ADDR_P0_PU     = 8'h18;
    localparam logic [7:0] ADDR_P1_PU     = 8'h19;
    localparam logic [7:0] ADDR_P2_PU     = 8'h1a;
    localparam logic [7:0] ADDR_P3_PU     = 8'h1b;
    // Control mode selects (one is control mode) and port function selects (one is port).
    localparam logic [7:0] ADDR_P0_CTRL   = 8'h20;
    localparam logic [7:0] ADDR_P2_CTRL   = 8'h21;
    localparam logic [7:0] ADDR_P3_CTRL   = 8'h22;
    localparam logic [7:0] ADDR_P6_CTRL   = 8'h23;
    localparam logic [7:0] ADDR_P7_FUNC   = 8'h24;
    localparam logic [7:0] ADDR_P8_FUNC   = 8'h25;
    // Interrupt edge selects, status and mask.
    localparam logic [7:0] ADDR_EDGE_RISE = 8'h28;
    localparam logic [7:0] ADDR_EDGE_FALL = 8'h29;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h31;

    // Status bit positions: 3..0 external interrupts, 4 and 5 key return.
    localparam int IRQ_KEY_POS  = 4;
    localparam int IRQ_KEY2_POS = 5;
    localparam int IRQ_W        = 6;

    localparam logic [7:0] RST_DIR   = 8'hff;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_PU    = 8'h00;
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [7:0] RST_FUNC  = 8'hff;
    localparam logic [7:0] RST_RISE  = 8'h00;
    localparam logic [7:0] RST_FALL  = 8'h0f;
    localparam logic [7:0] RST_MASK  = 8'h00;

endpackage

//--- src/pfm_sync.sv
// Three-stage input synchroniser whose output follows once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module pfm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Data
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    wire  [W-1:0] next_dout = (ff2 & ff3) | (dout & (ff2 ^ ff3));

    // Holding the old value on disagreement filters single-cycle glitches.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ff1  <= '0;
            ff2  <= '0;
            ff3  <= '0;
            dout <= '0;
        end
        else
        begin
            ff1  <= din;
            ff2  <= ff1;
            ff3  <= ff2;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

//--- src/pfm_edge.sv
// Per-bit edge detector with separate rising and falling enables.
`timescale 1ns/10ps
`default_nettype none
module pfm_edge #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Level in, enables and pulse out
    input  wire logic [W-1:0] sig,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    output var  logic [W-1:0] pulse
);
    logic [W-1:0] prev;
    wire  [W-1:0] next_pulse = (sig & ~prev & rise_en) | (~sig & prev & fall_en);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev  <= '0;
            pulse <= '0;
        end
        else
        begin
            prev  <= sig;
            pulse <= next_pulse;
        end
    end
endmodule
`default_nettype wire

//--- src/pfm_top.sv
// Port pin function multiplexer: port registers, pin drivers and pin-change interrupts.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pfm_top (
    // Clock and reset
    input  wire logic                            CLOCK,
    input  wire logic                            RST_B,
    // Register port
    input  wire logic [pfm_pkg::ADDR_W-1:0]      ADDR,
    input  wire logic [pfm_pkg::DATA_W-1:0]      WDATA,
    input  wire logic                            WR,
    input  wire logic                            RD,
    output var  logic [pfm_pkg::DATA_W-1:0]      RDATA,
    output var  logic                            IRQ,
    // Port 0
    input  wire logic [pfm_pkg::P0_W-1:0]        P0_IN,
    output var  logic [pfm_pkg::P0_W-1:0]        P0_OUT,
    output var  logic [pfm_pkg::P0_W-1:0]        P0_OE_B,
    output var  logic [pfm_pkg::P0_W-1:0]        P0_PU,
    // Port 1
    input  wire logic [pfm_pkg::P1_W-1:0]        P1_IN,
    output var  logic [pfm_pkg::P1_W-1:0]        P1_OUT,
    output var  logic [pfm_pkg::P1_W-1:0]        P1_OE_B,
    output var  logic [pfm_pkg::P1_W-1:0]        P1_PU,
    // Port 2 and serial units
    input  wire logic [pfm_pkg::P2_W-1:0]        P2_IN,
    output var  logic [pfm_pkg::P2_W-1:0]        P2_OUT,
    output var  logic [pfm_pkg::P2_W-1:0]        P2_OE_B,
    output var  logic [pfm_pkg::P2_W-1:0]        P2_PU,
    input  wire logic [pfm_pkg::P2_W-1:0]        SERIAL_OUT,
    output var  logic [pfm_pkg::P2_W-1:0]        SERIAL_IN,
    // Port 3 and timer, capture and remote units
    input  wire logic [pfm_pkg::P3_W-1:0]        P3_IN,
    output var  logic [pfm_pkg::P3_W-1:0]        P3_OUT,
    output var  logic [pfm_pkg::P3_W-1:0]        P3_OE_B,
    output var  logic [pfm_pkg::P3_W-1:0]        P3_PU,
    input  wire logic [pfm_pkg::P3_W-1:0]        TIMER_OUT,
    output var  logic [pfm_pkg::P3_W-1:0]        TIMER_IN,
    // Port 5, open drain
    input  wire logic [pfm_pkg::P5_W-1:0]        P5_IN,
    output var  logic [pfm_pkg::P5_W-1:0]        P5_OUT,
    output var  logic [pfm_pkg::P5_W-1:0]        P5_OE_B,
    // Port 6 and analog converter
    input  wire logic [pfm_pkg::P6_W-1:0]        P6_IN,
    output var  logic [pfm_pkg::P6_W-1:0]        ANALOG_SEL,
    // Port 7 and port 8 shared with LCD segments
    input  wire logic [pfm_pkg::P7_W-1:0]        P7_IN,
    output var  logic [pfm_pkg::P7_W-1:0]        P7_OUT,
    output var  logic [pfm_pkg::P7_W-1:0]        P7_OE_B,
    input  wire logic [pfm_pkg::P8_W-1:0]        P8_IN,
    output var  logic [pfm_pkg::P8_W-1:0]        P8_OUT,
    output var  logic [pfm_pkg::P8_W-1:0]        P8_OE_B,
    input  wire logic [pfm_pkg::SEG_W-1:0]       LCD_SEGMENT_OUTPUTS
);
    import pfm_pkg::*;

    // Read value of a bidirectional bit: latch when output, pin when input.
    function automatic logic [7:0] port_read(input logic [7:0] dir,
                                             input logic [7:0] latch,
                                             input logic [7:0] pin);
        port_read = (dir & pin) | (~dir & latch);
    endfunction

    // Register state.
    logic [P0_W-1:0]  p0_latch;
    logic [P1_W-1:0]  p1_latch;
    logic [P2_W-1:0]  p2_latch;
    logic [P3_W-1:0]  p3_latch;
    logic [P5_W-1:0]  p5_latch;
    logic [P8_W-1:0]  p8_latch;
    logic [P0_W-1:0]  port0_direction_reg;
    logic [P1_W-1:0]  port1_direction_reg;
    logic [P2_W-1:0]  port2_direction_reg;
    logic [P3_W-1:0]  port3_direction_reg;
    logic [P5_W-1:0]  port5_direction_reg;
    logic [P8_W-1:0]  port8_direction_reg;
    logic [P0_W-1:0]  port0_pullup_reg;
    logic [P1_W-1:0]  port1_pullup_reg;
    logic [P2_W-1:0]  port2_pullup_reg;
    logic [P3_W-1:0]  port3_pullup_reg;
    logic [P0_W-1:0]  p0_ctrl;
    logic [P2_W-1:0]  p2_ctrl;
    logic [P3_W-1:0]  p3_ctrl;
    logic [P6_W-1:0]  p6_ctrl;
    logic [P7_W-1:0]  p7_func;
    logic [P8_W-1:0]  p8_func;
    logic [INT_W-1:0] edge_rise;
    logic [INT_W-1:0] edge_fall;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;

    // Synchronised pins.
    logic [PIN_W-1:0] pins_sync;
    logic [INT_W-1:0] int_pulse;
    logic [P0_W-1:0]  key_pulse;
    logic [P6_W-1:0]  key2_pulse;

    pfm_sync #(.W(PIN_W)) u_sync (
        .clk   (CLOCK),
        .rst_b (RST_B),
        .din   ({P8_IN, P7_IN, P6_IN, P5_IN, P3_IN, P2_IN, P1_IN, P0_IN}),
        .dout  (pins_sync)
    );

    wire [P0_W-1:0] s0 = pins_sync[7:0];
    wire [P1_W-1:0] s1 = pins_sync[9:8];
    wire [P2_W-1:0] s2 = pins_sync[15:10];
    wire [P3_W-1:0] s3 = pins_sync[20:16];
    wire [P5_W-1:0] s5 = pins_sync[24:21];
    wire [P6_W-1:0] s6 = pins_sync[32:25];
    wire [P7_W-1:0] s7 = pins_sync[36:33];
    wire [P8_W-1:0] s8 = pins_sync[44:37];

    // External interrupts share port 3 bits 3..0 in control mode.
    wire [INT_W-1:0] int_level = s3[INT_W-1:0] & p3_ctrl[INT_W-1:0];

    pfm_edge #(.W(INT_W)) u_int_edge (
        .clk     (CLOCK),
        .rst_b   (RST_B),
        .sig     (int_level),
        .rise_en (edge_rise & p3_ctrl[INT_W-1:0]),
        .fall_en (edge_fall & p3_ctrl[INT_W-1:0]),
        .pulse   (int_pulse)
    );

    // A key press pulls a control-mode pin low, so only falling edges count.
    pfm_edge #(.W(P0_W)) u_key_edge (
        .clk     (CLOCK),
        .rst_b   (RST_B),
        .sig     (s0 | ~p0_ctrl),
        .rise_en ('0),
        .fall_en (p0_ctrl),
        .pulse   (key_pulse)
    );

    pfm_edge #(.W(P6_W)) u_key2_edge (
        .clk     (CLOCK),
        .rst_b   (RST_B),
        .sig     (s6 | ~p6_ctrl),
        .rise_en ('0),
        .fall_en (p6_ctrl),
        .pulse   (key2_pulse)
    );

    // Register decode.
    wire wr_p0    = WR && (ADDR == ADDR_P0_DATA);
    wire wr_p1    = WR && (ADDR == ADDR_P1_DATA);
    wire wr_p2    = WR && (ADDR == ADDR_P2_DATA);
    wire wr_p3    = WR && (ADDR == ADDR_P3_DATA);
    wire wr_p5    = WR && (ADDR == ADDR_P5_DATA);
    wire wr_p8    = WR && (ADDR == ADDR_P8_DATA);
    wire wr_d0    = WR && (ADDR == ADDR_P0_DIR);
    wire wr_d1    = WR && (ADDR == ADDR_P1_DIR);
    wire wr_d2    = WR && (ADDR == ADDR_P2_DIR);
    wire wr_d3    = WR && (ADDR == ADDR_P3_DIR);
    wire wr_d5    = WR && (ADDR == ADDR_P5_DIR);
    wire wr_d8    = WR && (ADDR == ADDR_P8_DIR);
    wire wr_u0    = WR && (ADDR == ADDR_P0_PU);
    wire wr_u1    = WR && (ADDR == ADDR_P1_PU);
    wire wr_u2    = WR && (ADDR == ADDR_P2_PU);
    wire wr_u3    = WR && (ADDR == ADDR_P3_PU);
    wire wr_c0    = WR && (ADDR == ADDR_P0_CTRL);
    wire wr_c2    = WR && (ADDR == ADDR_P2_CTRL);
    wire wr_c3    = WR && (ADDR == ADDR_P3_CTRL);
    wire wr_c6    = WR && (ADDR == ADDR_P6_CTRL);
    wire wr_f7    = WR && (ADDR == ADDR_P7_FUNC);
    wire wr_f8    = WR && (ADDR == ADDR_P8_FUNC);
    wire wr_rise  = WR && (ADDR == ADDR_EDGE_RISE);
    wire wr_fall  = WR && (ADDR == ADDR_EDGE_FALL);
    wire wr_mask  = WR && (ADDR == ADDR_IRQ_MASK);
    wire rd_stat  = RD && (ADDR == ADDR_IRQ_STAT);

    // Port 7 bits read zero while they serve as segment outputs.
    wire [7:0] p7_read = {4'h0, s7 & p7_func};

    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (ADDR)
            ADDR_P0_DATA:   rd_mux = port_read(port0_direction_reg, p0_latch, s0);
            ADDR_P1_DATA:   rd_mux = port_read({6'h00, port1_direction_reg},
                                               {6'h00, p1_latch}, {6'h00, s1});
            ADDR_P2_DATA:   rd_mux = port_read({2'h0, port2_direction_reg},
                                               {2'h0, p2_latch}, {2'h0, s2});
            ADDR_P3_DATA:   rd_mux = port_read({3'h0, port3_direction_reg},
                                               {3'h0, p3_latch}, {3'h0, s3});
            ADDR_P5_DATA:   rd_mux = port_read({4'h0, port5_direction_reg},
                                               {4'h0, p5_latch}, {4'h0, s5});
            ADDR_P6_DATA:   rd_mux = s6;
            ADDR_P7_DATA:   rd_mux = p7_read;
            ADDR_P8_DATA:   rd_mux = port_read(port8_direction_reg, p8_latch, s8 & p8_func);
            ADDR_P0_DIR:    rd_mux = port0_direction_reg;
            ADDR_P1_DIR:    rd_mux = {6'h00, port1_direction_reg};
            ADDR_P2_DIR:    rd_mux = {2'h0, port2_direction_reg};
            ADDR_P3_DIR:    rd_mux = {3'h0, port3_direction_reg};
            ADDR_P5_DIR:    rd_mux = {4'h0, port5_direction_reg};
            ADDR_P8_DIR:    rd_mux = port8_direction_reg;
            ADDR_P0_PU:     rd_mux = port0_pullup_reg;
            ADDR_P1_PU:     rd_mux = {6'h00, port1_pullup_reg};
            ADDR_P2_PU:     rd_mux = {2'h0, port2_pullup_reg};
            ADDR_P3_PU:     rd_mux = {3'h0, port3_pullup_reg};
            ADDR_P0_CTRL:   rd_mux = p0_ctrl;
            ADDR_P2_CTRL:   rd_mux = {2'h0, p2_ctrl};
            ADDR_P3_CTRL:   rd_mux = {3'h0, p3_ctrl};
            ADDR_P6_CTRL:   rd_mux = p6_ctrl;
            ADDR_P7_FUNC:   rd_mux = {4'h0, p7_func};
            ADDR_P8_FUNC:   rd_mux = p8_func;
            ADDR_EDGE_RISE: rd_mux = {4'h0, edge_rise};
            ADDR_EDGE_FALL: rd_mux = {4'h0, edge_fall};
            ADDR_IRQ_STAT:  rd_mux = {2'h0, irq_stat};
            ADDR_IRQ_MASK:  rd_mux = {2'h0, irq_mask};
            default:        rd_mux = 8'h00;
        endcase
    end

    // A new event in the clearing read survives, so no edge is lost.
    wire [IRQ_W-1:0] irq_set = {|key2_pulse, |key_pulse, int_pulse};
    wire [IRQ_W-1:0] next_irq_stat = (rd_stat ? '0 : irq_stat) | irq_set;

    // Pin drivers; direction one means input, output enable is active low.
    wire [P0_W-1:0] next_p0_oe_b = port0_direction_reg;
    wire [P1_W-1:0] next_p1_oe_b = port1_direction_reg;
    wire [P2_W-1:0] next_p2_oe_b = port2_direction_reg;
    wire [P3_W-1:0] next_p3_oe_b = port3_direction_reg;
    wire [P2_W-1:0] next_p2_out  = (p2_ctrl & SERIAL_OUT) | (~p2_ctrl & p2_latch);
    wire [P3_W-1:0] next_p3_out  = (p3_ctrl & TIMER_OUT) | (~p3_ctrl & p3_latch);
    // Open drain: enable only to pull a zero, the pin's high comes from outside.
    wire [P5_W-1:0] next_p5_oe_b = port5_direction_reg | p5_latch;
    wire [P7_W-1:0] seg7         = LCD_SEGMENT_OUTPUTS[3:0];
    wire [P8_W-1:0] seg8         = LCD_SEGMENT_OUTPUTS[11:4];
    wire [P8_W-1:0] next_p8_out  = (p8_func & p8_latch) | (~p8_func & seg8);
    wire [P8_W-1:0] next_p8_oe_b = p8_func & port8_direction_reg;

    // Register writes.
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            p0_latch            <= RST_LATCH[P0_W-1:0];
            p1_latch            <= RST_LATCH[P1_W-1:0];
            p2_latch            <= RST_LATCH[P2_W-1:0];
            p3_latch            <= RST_LATCH[P3_W-1:0];
            p5_latch            <= RST_LATCH[P5_W-1:0];
            p8_latch            <= RST_LATCH[P8_W-1:0];
            port0_direction_reg <= RST_DIR[P0_W-1:0];
            port1_direction_reg <= RST_DIR[P1_W-1:0];
            port2_direction_reg <= RST_DIR[P2_W-1:0];
            port3_direction_reg <= RST_DIR[P3_W-1:0];
            port5_direction_reg <= RST_DIR[P5_W-1:0];
            port8_direction_reg <= RST_DIR[P8_W-1:0];
            port0_pullup_reg    <= RST_PU[P0_W-1:0];
            port1_pullup_reg    <= RST_PU[P1_W-1:0];
            port2_pullup_reg    <= RST_PU[P2_W-1:0];
            port3_pullup_reg    <= RST_PU[P3_W-1:0];
            p0_ctrl             <= RST_CTRL[P0_W-1:0];
            p2_ctrl             <= RST_CTRL[P2_W-1:0];
            p3_ctrl             <= RST_CTRL[P3_W-1:0];
            p6_ctrl             <= RST_CTRL[P6_W-1:0];
            p7_func             <= RST_FUNC[P7_W-1:0];
            p8_func             <= RST_FUNC[P8_W-1:0];
            edge_rise           <= RST_RISE[INT_W-1:0];
            edge_fall           <= RST_FALL[INT_W-1:0];
            irq_mask            <= RST_MASK[IRQ_W-1:0];
            irq_stat            <= '0;
        end
        else
        begin
            if (wr_p0)   p0_latch            <= WDATA[P0_W-1:0];
            if (wr_p1)   p1_latch            <= WDATA[P1_W-1:0];
            if (wr_p2)   p2_latch            <= WDATA[P2_W-1:0];
            if (wr_p3)   p3_latch            <= WDATA[P3_W-1:0];
            if (wr_p5)   p5_latch            <= WDATA[P5_W-1:0];
            if (wr_p8)   p8_latch            <= WDATA[P8_W-1:0];
            if (wr_d0)   port0_direction_reg <= WDATA[P0_W-1:0];
            if (wr_d1)   port1_direction_reg <= WDATA[P1_W-1:0];
            if (wr_d2)   port2_direction_reg <= WDATA[P2_W-1:0];
            if (wr_d3)   port3_direction_reg <= WDATA[P3_W-1:0];
            if (wr_d5)   port5_direction_reg <= WDATA[P5_W-1:0];
            if (wr_d8)   port8_direction_reg <= WDATA[P8_W-1:0];
            if (wr_u0)   port0_pullup_reg    <= WDATA[P0_W-1:0];
            if (wr_u1)   port1_pullup_reg    <= WDATA[P1_W-1:0];
            if (wr_u2)   port2_pullup_reg    <= WDATA[P2_W-1:0];
            if (wr_u3)   port3_pullup_reg    <= WDATA[P3_W-1:0];
            if (wr_c0)   p0_ctrl             <= WDATA[P0_W-1:0];
            if (wr_c2)   p2_ctrl             <= WDATA[P2_W-1:0];
            if (wr_c3)   p3_ctrl             <= WDATA[P3_W-1:0];
            if (wr_c6)   p6_ctrl             <= WDATA[P6_W-1:0];
            if (wr_f7)   p7_func             <= WDATA[P7_W-1:0];
            if (wr_f8)   p8_func             <= WDATA[P8_W-1:0];
            if (wr_rise) edge_rise           <= WDATA[INT_W-1:0];
            if (wr_fall) edge_fall           <= WDATA[INT_W-1:0];
            if (wr_mask) irq_mask            <= WDATA[IRQ_W-1:0];
            irq_stat <= next_irq_stat;
        end
    end

    // Every output is registered, so pins change one cycle after a register write.
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            RDATA      <= '0;
            IRQ        <= 1'b0;
            P0_OUT     <= '0;
            P0_OE_B    <= '1;
            P0_PU      <= '0;
            P1_OUT     <= '0;
            P1_OE_B    <= '1;
            P1_PU      <= '0;
            P2_OUT     <= '0;
            P2_OE_B    <= '1;
            P2_PU      <= '0;
            SERIAL_IN  <= '0;
            P3_OUT     <= '0;
            P3_OE_B    <= '1;
            P3_PU      <= '0;
            TIMER_IN   <= '0;
            P5_OUT     <= '0;
            P5_OE_B    <= '1;
            ANALOG_SEL <= '0;
            P7_OUT     <= '0;
            P7_OE_B    <= '1;
            P8_OUT     <= '0;
            P8_OE_B    <= '1;
        end
        else
        begin
            RDATA      <= RD ? rd_mux : '0;
            IRQ        <= |(next_irq_stat & irq_mask);
            P0_OUT     <= p0_latch;
            P0_OE_B    <= next_p0_oe_b;
            P0_PU      <= port0_pullup_reg & port0_direction_reg;
            P1_OUT     <= p1_latch;
            P1_OE_B    <= next_p1_oe_b;
            P1_PU      <= port1_pullup_reg & port1_direction_reg;
            P2_OUT     <= next_p2_out;
            P2_OE_B    <= next_p2_oe_b;
            P2_PU      <= port2_pullup_reg & port2_direction_reg;
            SERIAL_IN  <= s2 & p2_ctrl;
            P3_OUT     <= next_p3_out;
            P3_OE_B    <= next_p3_oe_b;
            P3_PU      <= port3_pullup_reg & port3_direction_reg;
            TIMER_IN   <= s3 & p3_ctrl;
            P5_OUT     <= '0;
            P5_OE_B    <= next_p5_oe_b;
            ANALOG_SEL <= p6_ctrl;
            P7_OUT     <= seg7 & ~p7_func;
            P7_OE_B    <= p7_func;
            P8_OUT     <= next_p8_out;
            P8_OE_B    <= next_p8_oe_b;
        end
    end
endmodule
`default_nettype wire

//--- bench/pfm_pad.sv
// Pad model: each pin shows the design's drive when enabled, else the outside level.
`timescale 1ns/10ps
`default_nettype none
module pfm_pad #(
    parameter int W = 1
) (
    // Pad signals
    input  wire logic [W-1:0] oe_b,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] ext,
    output var  logic [W-1:0] pin
);
    // Open-drain bits carry out as zero, so an enabled drain pulls low only.
    assign pin = (oe_b & ext) | (~oe_b & out);
endmodule
`default_nettype wire

//--- bench/pfm_checker.sv
// Concurrent checks on the port multiplexer's outputs.
`timescale 1ns/10ps
`default_nettype none
module pfm_checker (
    // Watched ports
    input wire logic        CLOCK,
    input wire logic        RST_B,
    input wire logic [7:0]  ADDR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic [7:0]  P0_OE_B,
    input wire logic [7:0]  P0_PU,
    input wire logic [1:0]  P1_OE_B,
    input wire logic [1:0]  P1_PU,
    input wire logic [5:0]  P2_OE_B,
    input wire logic [5:0]  P2_PU,
    input wire logic [3:0]  P5_OUT,
    input wire logic [3:0]  P7_OUT,
    input wire logic [3:0]  P7_OE_B,
    input wire logic [11:0] LCD_SEGMENT_OUTPUTS
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    sequence rd_hole;
        RD && ADDR == 8'h3f;
    endsequence
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("RDATA not idle");
    chk_rdata_hole: assert property (rd_hole |=> RDATA == 8'h00)
        else $error("hole not zero");
    chk_p0_pullup: assert property ((P0_PU & ~P0_OE_B) == 8'h00) else $error("P0 pull-up");
    chk_p1_pullup: assert property ((P1_PU & ~P1_OE_B) == 2'h0) else $error("P1 pull-up");
    chk_p2_pullup: assert property ((P2_PU & ~P2_OE_B) == 6'h00) else $error("P2 pull-up");
    chk_p5_drain: assert property (P5_OUT == 4'h0) else $error("P5 drives high");
    chk_p7_segment: assert property (
        ((P7_OUT ^ $past(LCD_SEGMENT_OUTPUTS[3:0])) & ~P7_OE_B) == 4'h0) else $error("P7 segment");
    chk_p7_quiet: assert property ((P7_OUT & P7_OE_B) == 4'h0) else $error("P7 port drive");
endmodule
bind pfm_top pfm_checker pfm_checker_i (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .RD(RD),
    .RDATA(RDATA), .P0_OE_B(P0_OE_B), .P0_PU(P0_PU), .P1_OE_B(P1_OE_B), .P1_PU(P1_PU),
    .P2_OE_B(P2_OE_B), .P2_PU(P2_PU), .P5_OUT(P5_OUT), .P7_OUT(P7_OUT), .P7_OE_B(P7_OE_B),
    .LCD_SEGMENT_OUTPUTS(LCD_SEGMENT_OUTPUTS));
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench of the port multiplexer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk = 0, rst_b = 0, wr = 0, rd = 0, irq;
    logic [7:0]  addr = 0, wdata = 0, rdata, p6 = 8'h01, ana;
    wire  [36:0] po, oe, pin;
    logic [36:0] ext = '0;
    wire  [20:0] pu;
    logic [5:0]  si;
    logic [4:0]  ti;
    int          n_errors = 0, compares = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    pfm_top pfm_top_i (.CLOCK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IRQ(irq), .P0_IN(pin[7:0]), .P0_OUT(po[7:0]), .P0_OE_B(oe[7:0]),
        .P0_PU(pu[7:0]), .P1_IN(pin[9:8]), .P1_OUT(po[9:8]), .P1_OE_B(oe[9:8]), .P1_PU(pu[9:8]),
        .P2_IN(pin[15:10]), .P2_OUT(po[15:10]), .P2_OE_B(oe[15:10]), .P2_PU(pu[15:10]),
        .SERIAL_OUT(6'h01), .SERIAL_IN(si), .P3_IN(pin[20:16]), .P3_OUT(po[20:16]),
        .P3_OE_B(oe[20:16]), .P3_PU(pu[20:16]), .TIMER_OUT(5'h0a), .TIMER_IN(ti),
        .P5_IN(pin[24:21]), .P5_OUT(po[24:21]), .P5_OE_B(oe[24:21]), .P6_IN(p6), .ANALOG_SEL(ana),
        .P7_IN(pin[28:25]), .P7_OUT(po[28:25]), .P7_OE_B(oe[28:25]), .P8_IN(pin[36:29]),
        .P8_OUT(po[36:29]), .P8_OE_B(oe[36:29]), .LCD_SEGMENT_OUTPUTS(12'ha55));
    pfm_pad #(.W(37)) pfm_pad_i (.oe_b(oe), .out(po), .ext(ext), .pin(pin));
    task chk(string n, logic [7:0] s, logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task wt(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wrt(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task rdc(string n, logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a; rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk(n, rdata, e);
    endtask
    task end_of_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // A hang is cut after far more cycles than the tests take.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            end_of_test;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdc("dir0", 8'h10, 8'hff);
        rdc("fall", 8'h29, 8'h0f);
        rdc("hole", 8'h3f, 8'h00);
        rdc("p6", 8'h05, 8'h01);
        $display("reset test done");
        ext[7:0] <= 8'h3d;
        wrt(8'h00, 8'ha5);
        wrt(8'h10, 8'h0f);
        wrt(8'h18, 8'hff);
        wt(8);
        rdc("p0", 8'h00, 8'had);
        chk("p0out", po[7:4], 8'h0a);
        chk("p0oe", oe[7:0], 8'h0f);
        chk("p0pu", pu[7:0], 8'h0f);
        wrt(8'h11, 8'h01);
        wrt(8'h19, 8'h03);
        wrt(8'h14, 8'h00);
        wrt(8'h04, 8'h05);
        wrt(8'h01, 8'h02);
        wrt(8'h1b, 8'h03);
        wt(2);
        chk("p1pu", pu[9:8], 8'h01);
        chk("p1out", po[9:8], 8'h02);
        chk("p1oe", oe[9:8], 8'h01);
        chk("p3pu", pu[20:16], 8'h03);
        chk("p5oe", oe[24:21], 8'h05);
        $display("port test done");
        wrt(8'h22, 8'h0f);
        wrt(8'h28, 8'h05);
        wrt(8'h29, 8'h06);
        wrt(8'h31, 8'h0f);
        ext[20:16] <= 5'h0f;
        wt(8);
        chk("irq", irq, 8'h01);
        chk("tin", ti, 8'h0f);
        chk("p3out", po[20:16], 8'h0a);
        rdc("st", 8'h30, 8'h05);
        chk("irq0", irq, 8'h00);
        wrt(8'h31, 8'h00);
        ext[20:16] <= 5'h00;
        wt(8);
        chk("mask", irq, 8'h00);
        rdc("st", 8'h30, 8'h06);
        wrt(8'h20, 8'h01);
        wrt(8'h23, 8'h01);
        ext[0] <= 1'b0;
        p6 <= 8'h00;
        wt(8);
        chk("ana", ana, 8'h01);
        rdc("key", 8'h30, 8'h30);
        $display("interrupt test done");
        wrt(8'h24, 8'h0c);
        wrt(8'h25, 8'hf0);
        wrt(8'h07, 8'ha0);
        ext[28:25] <= 4'hf;
        wt(8);
        chk("p7oe", oe[28:25], 8'h0c);
        chk("p7out", po[28:25], 8'h01);
        rdc("p7", 8'h06, 8'h0c);
        chk("p8oe", oe[36:29], 8'hf0);
        chk("p8out", po[36:29], 8'ha5);
        wrt(8'h21, 8'h3f);
        wrt(8'h12, 8'h3e);
        ext[15:10] <= 6'h3e;
        wt(8);
        chk("p2out", po[10], 8'h01);
        chk("sin", si, 8'h3f);
        $display("function test done");
        rst_b <= 1'b0;
        wt(1);
        chk("rst", oe[7:0], 8'hff);
        $display("reset input test done");
        end_of_test;
    end
endmodule
`default_nettype wire
